// [hdl/cdp_pkg.sv]
// Constants, register map and carrier types of the clock divider and PLL control block
package cdp_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [7:0] OFF_PERIPH_DIV = 8'h18;
	localparam logic [7:0] OFF_PLL_CTRL = 8'h20;
	localparam logic [7:0] OFF_POW2_OUT = 8'h24;
	localparam logic [7:0] OFF_CARD_SEL = 8'h34;
	localparam logic [7:0] OFF_CARD_DIV = 8'h38;

	localparam logic [31:0] RST_PERIPH_DIV = 32'h0000_0000;
	localparam logic [31:0] RST_PLL_CTRL = 32'h0005_C22E;
	localparam logic [31:0] RST_POW2_OUT = 32'h0000_0000;
	localparam logic [31:0] RST_CARD_SEL = 32'h0000_003F;
	localparam logic [31:0] RST_CARD_DIV = 32'h0000_0000;

	// Writable bits; everything else reads as zero
	localparam logic [31:0] MASK_PERIPH_DIV = 32'h00FF_0FFF;
	localparam logic [31:0] MASK_PLL_CTRL = 32'h000F_FFFF;
	localparam logic [31:0] MASK_POW2_OUT = 32'h0000_001F;
	localparam logic [31:0] MASK_CARD_SEL = 32'h0000_003F;
	localparam logic [31:0] MASK_CARD_DIV = 32'h00FF_FFFF;

	// Peripheral divide fields
	localparam int ADC_DIV_LSB = 16;
	localparam int UART_DIV_LSB = 8;
	localparam int USB_DIV_LSB = 4;
	localparam int BUS_DIV_LSB = 0;

	// PLL control fields
	localparam int PLL_REF_SEL_BIT = 19;
	localparam int PLL_GATE_BIT = 18;
	localparam int PLL_BYPASS_BIT = 17;
	localparam int PLL_PD_BIT = 16;
	localparam int PLL_OUT_DIV_LSB = 14;
	localparam int PLL_REF_DIV_LSB = 9;
	localparam int PLL_FB_DIV_LSB = 0;
	localparam logic [5:0] PLL_DIVISOR_OFFSET = 6'h02;

	// Power-of-two output fields
	localparam int POW2_EN_BIT = 4;
	localparam int POW2_SEL_LSB = 0;
	localparam int POW2_CW = 17;

	// Smart card fields, one pair of select bits and one divide byte per card
	localparam int CARD_COUNT = 3;
	localparam int CARD_SEL_W = 2;
	localparam int CARD_DIV_W = 8;

	// Source select codes shared by card and converter selectors
	localparam logic [1:0] SRC_XTAL = 2'h0;
	localparam logic [1:0] SRC_PLL = 2'h1;
	localparam logic [1:0] SRC_BUS = 2'h2;
	localparam logic [1:0] SRC_HIRC = 2'h3;
	// Power-of-two output source codes
	localparam logic [1:0] FSRC_XTAL = 2'h0;
	localparam logic [1:0] FSRC_LXT = 2'h1;
	localparam logic [1:0] FSRC_BUS = 2'h2;
	localparam logic [1:0] FSRC_HIRC = 2'h3;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
		logic read;
	} cdp_reg_req_type;

	typedef struct packed {
		logic refFromHirc;
		logic gateLow;
		logic bypass;
		logic powerDown;
		logic [2:0] outputDivisor;
		logic [5:0] referenceDivisor;
		logic [9:0] feedbackDivisor;
	} cdp_pll_cfg_type;

endpackage : cdp_pkg

// [hdl/cdp_divider.sv]
// Edge-counting clock divider on synchronised source levels
`timescale 1ns/1ps
module cdp_divider #(
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic srcLevel,
	input wire logic run,
	input wire logic [CW-1:0] terminal,
	output logic divClk
);
	logic srcPrev_q;
	logic [CW-1:0] count_q;
	logic divClk_q;
	logic srcEdge;

	assign srcEdge = srcLevel ^ srcPrev_q;
	assign divClk = divClk_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			srcPrev_q <= 1'b0;
		else
			srcPrev_q <= srcLevel;
	end

	// Toggle every terminal+1 source half periods; new terminal only read at reload
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count_q <= '0;
			divClk_q <= 1'b0;
		end
		else if (!run)
		begin
			count_q <= '0;
			divClk_q <= 1'b0;
		end
		else if (srcEdge)
		begin
			if (count_q == '0)
			begin
				count_q <= terminal;
				divClk_q <= ~divClk_q;
			end
			else
				count_q <= count_q - 1'b1;
		end
	end
endmodule : cdp_divider

// [hdl/cdp_clock_ctrl.sv]
// Clock controller: registers, source selectors, integer dividers, PLL control, power-of-two output
`timescale 1ns/1ps
// Notes on behaviour
// - Card source codes: 00 crystal, 01 PLL, 10 bus clock, 11 internal oscillator.
// - Converter clock is its source divided by eight-bit count plus one.
// - UART clock is its source divided by four-bit count plus one.
// - USB clock is always PLL output divided by four-bit count plus one.
// - Bus clock is its source divided by four-bit count plus one.
// - Each card clock divides its source by its own byte count plus one.
// - PLL reference: set picks internal oscillator, clear picks crystal.
// - PLL gate bit clear passes output, set holds it low.
// - Bypass set makes PLL output equal reference; clear is normal mode.
// - PLL power-down bit set powers down the PLL; set after reset.
// - Chip sleep enable also powers down the PLL.
// - PLL divisors: reference field plus two, feedback field plus two.
// - Output divider code 00 gives 1, 01 and 10 give 2, 11 gives 4.
// - Power-of-two output runs only while its enable bit is set.
// - Power-of-two output is input divided by two to the select plus one.
// - Power-of-two source: 00 crystal, 01 low speed crystal, 10 bus, 11 oscillator.
module cdp_clock_ctrl (
	input wire logic clk,
	input wire logic rstn,
	input wire cdp_pkg::cdp_reg_req_type regReq,
	output logic [31:0] regRdata,
	input wire logic xtalClk,
	input wire logic lowXtalClk,
	input wire logic hircClk,
	input wire logic pllCoreClk,
	input wire logic busSrcClk,
	input wire logic uartSrcClk,
	input wire logic hclkIn,
	input wire logic [1:0] adcSourceSelect,
	input wire logic [1:0] freqOutputSourceSelect,
	input wire logic chipSleepEnable,
	output cdp_pkg::cdp_pll_cfg_type pllCfg,
	output logic pllClk,
	output logic adcClk,
	output logic uartClk,
	output logic usbClk,
	output logic busClk,
	output logic [cdp_pkg::CARD_COUNT-1:0] cardClk,
	output logic freqDivOut
);
	localparam int NSRC = 7;

	logic [31:0] periphDiv_q;
	logic [31:0] pllCtrl_q;
	logic [31:0] pow2Out_q;
	logic [31:0] cardSel_q;
	logic [31:0] cardDiv_q;
	logic [31:0] rdata_q;
	logic [NSRC-1:0] srcMeta_q;
	logic [NSRC-1:0] srcSync_q;
	logic pllClk_q;
	logic xtalS, lowXtalS, hircS, pllCoreS, busSrcS, uartSrcS, hclkS;
	logic pllRefS;
	logic adcSrc;
	logic freqSrc;
	logic [cdp_pkg::CARD_COUNT-1:0] cardSrc;
	logic [3:0] pow2Sel;
	logic [cdp_pkg::POW2_CW-1:0] pow2Terminal;

	// Source select shared by converter and card selectors
	function automatic logic pickSource(input logic [1:0] sel, input logic xtal,
		input logic pll, input logic bus, input logic hirc);
		case (sel)
			cdp_pkg::SRC_XTAL: pickSource = xtal;
			cdp_pkg::SRC_PLL: pickSource = pll;
			cdp_pkg::SRC_BUS: pickSource = bus;
			cdp_pkg::SRC_HIRC: pickSource = hirc;
			default: pickSource = xtal;
		endcase
	endfunction : pickSource

	// Source clocks are sampled at the core rate; only sources well below half of it divide cleanly
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			srcMeta_q <= '0;
			srcSync_q <= '0;
		end
		else
		begin
			srcMeta_q <= {hclkIn, uartSrcClk, busSrcClk, pllCoreClk, hircClk, lowXtalClk, xtalClk};
			srcSync_q <= srcMeta_q;
		end
	end
	assign {hclkS, uartSrcS, busSrcS, pllCoreS, hircS, lowXtalS, xtalS} = srcSync_q;

	// Register writes
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			periphDiv_q <= cdp_pkg::RST_PERIPH_DIV;
			pllCtrl_q <= cdp_pkg::RST_PLL_CTRL;
			pow2Out_q <= cdp_pkg::RST_POW2_OUT;
			cardSel_q <= cdp_pkg::RST_CARD_SEL;
			cardDiv_q <= cdp_pkg::RST_CARD_DIV;
		end
		else if (regReq.write)
		begin
			case (regReq.addr)
				cdp_pkg::OFF_PERIPH_DIV: periphDiv_q <= regReq.wdata & cdp_pkg::MASK_PERIPH_DIV;
				cdp_pkg::OFF_PLL_CTRL: pllCtrl_q <= regReq.wdata & cdp_pkg::MASK_PLL_CTRL;
				cdp_pkg::OFF_POW2_OUT: pow2Out_q <= regReq.wdata & cdp_pkg::MASK_POW2_OUT;
				cdp_pkg::OFF_CARD_SEL: cardSel_q <= regReq.wdata & cdp_pkg::MASK_CARD_SEL;
				cdp_pkg::OFF_CARD_DIV: cardDiv_q <= regReq.wdata & cdp_pkg::MASK_CARD_DIV;
				default: ;
			endcase
		end
	end

	// Read data in the cycle after the strobe only; unmapped offsets read zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata_q <= '0;
		else if (regReq.read)
		begin
			case (regReq.addr)
				cdp_pkg::OFF_PERIPH_DIV: rdata_q <= periphDiv_q;
				cdp_pkg::OFF_PLL_CTRL: rdata_q <= pllCtrl_q;
				cdp_pkg::OFF_POW2_OUT: rdata_q <= pow2Out_q;
				cdp_pkg::OFF_CARD_SEL: rdata_q <= cardSel_q;
				cdp_pkg::OFF_CARD_DIV: rdata_q <= cardDiv_q;
				default: rdata_q <= '0;
			endcase
		end
		else
			rdata_q <= '0;
	end
	assign regRdata = rdata_q;

	// PLL configuration toward the analog core
	always_comb
	begin
		pllCfg.refFromHirc = pllCtrl_q[cdp_pkg::PLL_REF_SEL_BIT];
		pllCfg.gateLow = pllCtrl_q[cdp_pkg::PLL_GATE_BIT];
		pllCfg.bypass = pllCtrl_q[cdp_pkg::PLL_BYPASS_BIT];
		pllCfg.powerDown = pllCtrl_q[cdp_pkg::PLL_PD_BIT] | chipSleepEnable;
		pllCfg.referenceDivisor = {1'b0, pllCtrl_q[cdp_pkg::PLL_REF_DIV_LSB +: 5]}
			+ cdp_pkg::PLL_DIVISOR_OFFSET;
		pllCfg.feedbackDivisor = {1'b0, pllCtrl_q[cdp_pkg::PLL_FB_DIV_LSB +: 9]}
			+ {4'h0, cdp_pkg::PLL_DIVISOR_OFFSET};
		case (pllCtrl_q[cdp_pkg::PLL_OUT_DIV_LSB +: 2])
			2'h0: pllCfg.outputDivisor = 3'h1;
			2'h1: pllCfg.outputDivisor = 3'h2;
			2'h2: pllCfg.outputDivisor = 3'h2;
			default: pllCfg.outputDivisor = 3'h4;
		endcase
	end

	assign pllRefS = pllCfg.refFromHirc ? hircS : xtalS;

	// Gate overrides bypass; a powered-down core gives no clock
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pllClk_q <= 1'b0;
		else if (pllCfg.gateLow)
			pllClk_q <= 1'b0;
		else if (pllCfg.bypass)
			pllClk_q <= pllRefS;
		else
			pllClk_q <= pllCfg.powerDown ? 1'b0 : pllCoreS;
	end
	assign pllClk = pllClk_q;

	assign adcSrc = pickSource(adcSourceSelect, xtalS, pllClk_q, hclkS, hircS);

	cdp_divider #(.CW(8)) adcDiv (
		.clk(clk),
		.rstn(rstn),
		.srcLevel(adcSrc),
		.run(1'b1),
		.terminal(periphDiv_q[cdp_pkg::ADC_DIV_LSB +: 8]),
		.divClk(adcClk)
	);

	cdp_divider #(.CW(4)) uartDiv (
		.clk(clk),
		.rstn(rstn),
		.srcLevel(uartSrcS),
		.run(1'b1),
		.terminal(periphDiv_q[cdp_pkg::UART_DIV_LSB +: 4]),
		.divClk(uartClk)
	);

	cdp_divider #(.CW(4)) usbDiv (
		.clk(clk),
		.rstn(rstn),
		.srcLevel(pllClk_q),
		.run(1'b1),
		.terminal(periphDiv_q[cdp_pkg::USB_DIV_LSB +: 4]),
		.divClk(usbClk)
	);

	cdp_divider #(.CW(4)) busDiv (
		.clk(clk),
		.rstn(rstn),
		.srcLevel(busSrcS),
		.run(1'b1),
		.terminal(periphDiv_q[cdp_pkg::BUS_DIV_LSB +: 4]),
		.divClk(busClk)
	);

	genvar gi;
	generate
		for (gi = 0; gi < cdp_pkg::CARD_COUNT; gi++)
		begin : gCard
			assign cardSrc[gi] = pickSource(cardSel_q[gi*cdp_pkg::CARD_SEL_W +: 2],
				xtalS, pllClk_q, hclkS, hircS);
			cdp_divider #(.CW(cdp_pkg::CARD_DIV_W)) cardDiv (
				.clk(clk),
				.rstn(rstn),
				.srcLevel(cardSrc[gi]),
				.run(1'b1),
				.terminal(cardDiv_q[gi*cdp_pkg::CARD_DIV_W +: cdp_pkg::CARD_DIV_W]),
				.divClk(cardClk[gi])
			);
		end
	endgenerate

	always_comb
	begin
		case (freqOutputSourceSelect)
			cdp_pkg::FSRC_XTAL: freqSrc = xtalS;
			cdp_pkg::FSRC_LXT: freqSrc = lowXtalS;
			cdp_pkg::FSRC_BUS: freqSrc = hclkS;
			cdp_pkg::FSRC_HIRC: freqSrc = hircS;
			default: freqSrc = xtalS;
		endcase
	end

	// Toggle every 2^N source periods, i.e. 2^(N+1) half periods
	assign pow2Sel = pow2Out_q[cdp_pkg::POW2_SEL_LSB +: 4];
	assign pow2Terminal = (cdp_pkg::POW2_CW'(1) << (pow2Sel + 5'h01))
		- cdp_pkg::POW2_CW'(1);

	cdp_divider #(.CW(cdp_pkg::POW2_CW)) pow2Div (
		.clk(clk),
		.rstn(rstn),
		.srcLevel(freqSrc),
		.run(pow2Out_q[cdp_pkg::POW2_EN_BIT]),
		.terminal(pow2Terminal),
		.divClk(freqDivOut)
	);

endmodule : cdp_clock_ctrl

// [dv/cdp_assertions.sv]
// Port-level checks of the clock controller
`timescale 1ns/1ps
module cdp_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire cdp_pkg::cdp_reg_req_type regReq,
	input wire logic [31:0] regRdata,
	input wire logic chipSleepEnable,
	input wire cdp_pkg::cdp_pll_cfg_type pllCfg,
	input wire logic pllClk,
	input wire logic usbClk,
	input wire logic freqDivOut
);
	logic [31:0] pllQ;
	logic powEnQ;
	// Shadow copies, so checks need no hierarchical peeking
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pllQ <= cdp_pkg::RST_PLL_CTRL;
			powEnQ <= 1'b0;
		end
		else if (regReq.write && regReq.addr == cdp_pkg::OFF_PLL_CTRL)
			pllQ <= regReq.wdata & cdp_pkg::MASK_PLL_CTRL;
		else if (regReq.write && regReq.addr == cdp_pkg::OFF_POW2_OUT)
			powEnQ <= regReq.wdata[4];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence sPllRead;
		regReq.read && regReq.addr == cdp_pkg::OFF_PLL_CTRL;
	endsequence
	sequence sForcedLow;
		(pllCfg.powerDown && !pllCfg.bypass) [*2];
	endsequence
	AST_PLL_READ: assert property (sPllRead |=> regRdata == $past(pllQ))
		else $error("PLL control readback wrong");
	AST_RDATA_IDLE: assert property (!regReq.read |=> regRdata == 32'h0)
		else $error("read data not zero outside read answer");
	AST_PLL_MODES: assert property (pllCfg.refFromHirc == pllQ[19] && pllCfg.bypass == pllQ[17])
		else $error("PLL reference or bypass wrong");
	AST_PLL_DIVS: assert property (pllCfg.referenceDivisor == {1'b0, pllQ[13:9]} + 6'h02
		&& pllCfg.feedbackDivisor == {1'b0, pllQ[8:0]} + 10'h002)
		else $error("PLL divisors wrong");
	AST_OUT_DIV: assert property (pllCfg.outputDivisor == (pllQ[15:14] == 2'h0 ? 3'h1 :
		(pllQ[15:14] == 2'h3 ? 3'h4 : 3'h2)))
		else $error("PLL output divisor wrong");
	AST_PWR_DOWN: assert property (pllCfg.powerDown == (pllQ[16] || chipSleepEnable))
		else $error("PLL power-down wrong");
	AST_GATE_LOW: assert property (pllCfg.gateLow [*2] |-> !pllClk)
		else $error("gated PLL clock not low");
	AST_PD_LOW: assert property (sForcedLow |-> !pllClk || pllCfg.gateLow)
		else $error("powered-down PLL clock not low");
	AST_POW2_OFF: assert property (!powEnQ [*3] |-> !freqDivOut)
		else $error("disabled divider output not low");
	AST_USB_STILL: assert property (!pllClk [*8] |-> $stable(usbClk))
		else $error("USB clock moved without PLL clock");
endmodule : cdp_assertions

// [dv/cdp_sources.sv]
// Free-running oscillator and source clock models
`timescale 1ns/1ps
module cdp_sources #(
	parameter int HALF [7] = '{20, 100, 24, 12, 18, 28, 16}
) (
	output logic xtalClk,
	output logic lowXtalClk,
	output logic hircClk,
	output logic pllCoreClk,
	output logic busSrcClk,
	output logic uartSrcClk,
	output logic hclkIn
);
	logic [6:0] src;
	// Every source runs all the time, so any reselection is legal
	for (genvar i = 0; i < 7; i++)
	begin : g_src
		initial
		begin
			src[i] = 1'b0;
			#(1.1 * (i + 1));
			forever #(HALF[i]) src[i] = ~src[i];
		end
	end
	assign {hclkIn, uartSrcClk, busSrcClk, pllCoreClk, hircClk, lowXtalClk, xtalClk} = src;
endmodule : cdp_sources

// [dv/tb_clock_divider_pll_control.sv]
// Self-checking bench of the clock controller
`timescale 1ns/1ps
module tb_clock_divider_pll_control;
	typedef struct {
		logic [7:0] a;
		logic [31:0] d;
		logic [1:0] s;
		int i;
		int p;
	} cdp_row_type;
	localparam int HALF [7] = '{20, 100, 24, 12, 18, 28, 16};
	logic clk, rstn, chipSleepEnable;
	cdp_pkg::cdp_reg_req_type regReq;
	logic [31:0] regRdata, rd;
	logic xtalClk, lowXtalClk, hircClk, pllCoreClk, busSrcClk, uartSrcClk, hclkIn;
	logic [1:0] srcSel;
	cdp_pkg::cdp_pll_cfg_type pllCfg;
	logic pllClk, adcClk, uartClk, usbClk, busClk, freqDivOut;
	logic [2:0] cardClk;
	logic [8:0] outs;
	int mismatches, tests_run, cycles, got;
	logic [7:0] offs [5] = '{8'h18, 8'h20, 8'h24, 8'h34, 8'h38};
	logic [31:0] rsts [5] = '{cdp_pkg::RST_PERIPH_DIV, cdp_pkg::RST_PLL_CTRL,
		cdp_pkg::RST_POW2_OUT, cdp_pkg::RST_CARD_SEL, cdp_pkg::RST_CARD_DIV};
	logic [31:0] masks [5] = '{cdp_pkg::MASK_PERIPH_DIV, cdp_pkg::MASK_PLL_CTRL,
		cdp_pkg::MASK_POW2_OUT, cdp_pkg::MASK_CARD_SEL, cdp_pkg::MASK_CARD_DIV};
	logic [31:0] nod [4] = '{32'h1, 32'h2, 32'h2, 32'h4};
	// Expected periods in ns from the source half periods above
	cdp_row_type rows [22] = '{
		'{8'h20, 32'h0000_C22E, 2'h0, 8, 24},
		'{8'h20, 32'h0002_C22E, 2'h0, 8, 40},
		'{8'h20, 32'h000A_C22E, 2'h0, 8, 48},
		'{8'h20, 32'h0000_C22E, 2'h0, 8, 24},
		'{8'h38, 32'h0002_0103, 2'h0, 4, 192},
		'{8'h34, 32'h0000_0024, 2'h0, 4, 160},
		'{8'h34, 32'h0000_0024, 2'h0, 5, 48},
		'{8'h34, 32'h0000_0024, 2'h0, 6, 96},
		'{8'h34, 32'h0000_0039, 2'h0, 4, 96},
		'{8'h34, 32'h0000_0039, 2'h0, 6, 144},
		'{8'h18, 32'h0005_0312, 2'h0, 0, 240},
		'{8'h18, 32'h0005_0312, 2'h1, 0, 144},
		'{8'h18, 32'h0005_0312, 2'h2, 0, 192},
		'{8'h18, 32'h0005_0312, 2'h3, 0, 288},
		'{8'h18, 32'h0005_0312, 2'h0, 1, 224},
		'{8'h18, 32'h0005_0312, 2'h0, 2, 48},
		'{8'h18, 32'h0005_0312, 2'h0, 3, 108},
		'{8'h18, 32'h0000_0000, 2'h0, 3, 36},
		'{8'h24, 32'h0000_0011, 2'h0, 7, 160},
		'{8'h24, 32'h0000_0011, 2'h1, 7, 800},
		'{8'h24, 32'h0000_0013, 2'h2, 7, 512},
		'{8'h24, 32'h0000_0010, 2'h3, 7, 96}
	};
	assign outs = {pllClk, freqDivOut, cardClk, busClk, usbClk, uartClk, adcClk};
	cdp_sources #(.HALF(HALF)) u_src (.xtalClk(xtalClk), .lowXtalClk(lowXtalClk),
		.hircClk(hircClk), .pllCoreClk(pllCoreClk), .busSrcClk(busSrcClk),
		.uartSrcClk(uartSrcClk), .hclkIn(hclkIn));
	cdp_clock_ctrl u_dut (.clk(clk), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
		.xtalClk(xtalClk), .lowXtalClk(lowXtalClk), .hircClk(hircClk), .pllCoreClk(pllCoreClk),
		.busSrcClk(busSrcClk), .uartSrcClk(uartSrcClk), .hclkIn(hclkIn),
		.adcSourceSelect(srcSel), .freqOutputSourceSelect(srcSel),
		.chipSleepEnable(chipSleepEnable), .pllCfg(pllCfg), .pllClk(pllClk), .adcClk(adcClk),
		.uartClk(uartClk), .usbClk(usbClk), .busClk(busClk), .cardClk(cardClk),
		.freqDivOut(freqDivOut));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regReq.addr <= a;
		regReq.wdata <= d;
		regReq.write <= 1'b1;
		@(posedge clk);
		regReq.write <= 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic rdReg(input logic [7:0] a);
		@(posedge clk);
		regReq.addr <= a;
		regReq.read <= 1'b1;
		@(posedge clk);
		regReq.read <= 1'b0;
		@(negedge clk);
		rd = regRdata;
	endtask : rdReg
	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk32
	task automatic chkPer(input int i, input int e, input int g);
		tests_run++;
		if (g < e - 6 || g > e + 6)
		begin
			mismatches++;
			$display("ERROR period of output %0d expected %0d seen %0d", i, e, g);
		end
	endtask : chkPer
	// Averages two periods to halve the sampling jitter
	task automatic meas(input int i, output int ns);
		int n, r, t0;
		logic pv;
		n = 0;
		r = 0;
		t0 = 0;
		ns = 0;
		pv = outs[i];
		while (r < 4 && n < 3000)
		begin
			@(negedge clk);
			n++;
			if (outs[i] && !pv)
			begin
				r++;
				if (r == 2)
					t0 = n;
				if (r == 4)
					ns = (n - t0) * 2;
			end
			pv = outs[i];
		end
	endtask : meas
	task automatic lowFor(input int i, input string n);
		int h;
		h = 0;
		repeat (10) @(negedge clk);
		repeat (60)
		begin
			@(negedge clk);
			h += outs[i];
		end
		chk32(n, 32'h0, h);
	endtask : lowFor
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			results();
		end
	end
	initial
	begin
		regReq = '0;
		rstn = 1'b0;
		srcSel = 2'h0;
		chipSleepEnable = 1'b0;
		mismatches = 0;
		tests_run = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[k])
		begin
			wr(rows[k].a, rows[k].d);
			@(posedge clk);
			srcSel <= rows[k].s;
			meas(rows[k].i, got);
			chkPer(rows[k].i, rows[k].p, got);
			$display("Row %0d done", k);
		end
		// Second reset while every divider is running
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		foreach (offs[k])
		begin
			rdReg(offs[k]);
			chk32("reset value", rsts[k], rd);
		end
		chk32("reference divisor", 32'h3, {26'h0, pllCfg.referenceDivisor});
		chk32("feedback divisor", 32'h30, {22'h0, pllCfg.feedbackDivisor});
		chk32("output divisor", 32'h4, {29'h0, pllCfg.outputDivisor});
		$display("Reset test done");
		foreach (offs[k])
		begin
			wr(offs[k], 32'hFFFF_FFFF);
			rdReg(offs[k]);
			chk32("masked readback", masks[k], rd);
		end
		wr(8'h1C, 32'hFFFF_FFFF);
		rdReg(8'h1C);
		chk32("unmapped read", 32'h0, rd);
		$display("Register test done");
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h20, {16'h0, k[1:0], 5'h1F, 9'h1FF});
			chk32("output divisor", nod[k], {29'h0, pllCfg.outputDivisor});
			chk32("reference divisor", 32'h21, {26'h0, pllCfg.referenceDivisor});
			chk32("feedback divisor", 32'h201, {22'h0, pllCfg.feedbackDivisor});
		end
		@(posedge clk);
		chipSleepEnable <= 1'b1;
		@(negedge clk);
		chk32("sleep power-down", 32'h1, {31'h0, pllCfg.powerDown});
		lowFor(8, "pll clock asleep");
		@(posedge clk);
		chipSleepEnable <= 1'b0;
		wr(8'h20, 32'h0004_C22E);
		lowFor(8, "pll clock gated");
		wr(8'h24, 32'h0000_0001);
		lowFor(7, "divider output disabled");
		$display("PLL and enable test done");
		results();
	end
endmodule : tb_clock_divider_pll_control
bind cdp_clock_ctrl cdp_assertions u_chk (.clk(clk), .rstn(rstn), .regReq(regReq),
	.regRdata(regRdata), .chipSleepEnable(chipSleepEnable), .pllCfg(pllCfg),
	.pllClk(pllClk), .usbClk(usbClk), .freqDivOut(freqDivOut));
